//--- logic/zaf_pkg.sv
// Purpose: Shared constants and types for the zone access and fuse logic.
// Assumes: Nonvolatile cells are modelled as flip-flops loaded with the
//          fresh-card values at reset.
// Notes:   Written bits go to zero, erased words go to all ones.
// Notes on behaviour
// R01: The erase counter is live only in security mode 2 with the limit fuse still one.
// R02: While the counter is live, the second zone can be erased at most 128 times.
// R03: Each counted erase must be preceded by writing one still-set counter bit to zero.
// R04: While the counter is live, with all 128 counter bits zero and no bit newly spent, second zone erases are refused.
// R05: Counter bits may be written to zero, but erasing the counter is always refused.
// R06: With the limit fuse at zero the counter is ignored and erases are unlimited.
// R07: The test scratch zone allows read, write and erase with no condition.
// R08: The maker record zone can always be read.
// R09: Maker zone writes and erases need the verified code and both locking fuses intact.
// R10: A blown maker fuse makes the maker zone read-only.
// R11: A blown issuer fuse also makes the maker zone read-only.
// R12: Once the issuer fuse is blown the limit fuse cannot change.
// R13: Mode 1 holds while the issuer fuse reads all ones, mode 2 once it is programmed.
// R14: A successful password check sets a code-verified flag that gates protected writes.
// R15: In mode 2 the second zone is erased only with the verified code and the erase key.
// R16: Fuse bits are one-way; no erase returns them to one.
package zaf_pkg;
    // Array sizes
    localparam int         CTR_BITS   = 128;
    localparam int         WORD_BITS  = 16;
    localparam int         IDX_W      = 7;
    localparam int         WIDX_W     = 4;

    // Operation codes on the link
    localparam logic [1:0] OP_READ    = 2'h0;
    localparam logic [1:0] OP_WRITE   = 2'h1;
    localparam logic [1:0] OP_ERASE   = 2'h2;

    // Zone selects on the link
    localparam logic [2:0] ZN_TEST    = 3'h0;
    localparam logic [2:0] ZN_MAKER   = 3'h1;
    localparam logic [2:0] ZN_COUNTER = 3'h2;
    localparam logic [2:0] ZN_LIMIT   = 3'h3;
    localparam logic [2:0] ZN_ISSUER  = 3'h4;
    localparam logic [2:0] ZN_MFUSE   = 3'h5;
    localparam logic [2:0] ZN_AZ2     = 3'h6;

    // Fresh-card contents
    localparam logic [WORD_BITS-1:0] TEST_RST   = 16'hFFFF;
    localparam logic [WORD_BITS-1:0] MAKER_RST  = 16'hFFFF;
    localparam logic [WORD_BITS-1:0] ISSUER_RST = 16'hFFFF;
    localparam logic [CTR_BITS-1:0]  CTR_RST    = {CTR_BITS{1'b1}};
    localparam logic                 LIMIT_RST  = 1'h1;
    localparam logic                 MFUSE_RST  = 1'h1;

    // Link-side request sequencer
    typedef enum logic {
        ZAF_LK_IDLE,
        ZAF_LK_WAIT
    } zaf_lk_state_t;
endpackage

//--- logic/zaf_evt_if.sv
// Purpose: Carries one toggle event from one clock domain to another.
// Assumes: The sender flips src_tgl once per event.
// Notes:   dst_pulse is one cycle wide in the receiving domain.
`timescale 1ns/1ps
interface zaf_evt_if;
    logic src_tgl;
    logic dst_pulse;
    modport sender   (output src_tgl);
    modport receiver (input  dst_pulse);
    modport sync     (input  src_tgl, output dst_pulse);
endinterface

//--- logic/zaf_evt_sync.sv
// Purpose: Toggle synchroniser turning a far-domain toggle into a pulse.
// Assumes: Events are spaced by at least three receiving clock cycles.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
module zaf_evt_sync (
    // Receiving clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Event carrier
    zaf_evt_if.sync   ev
);
    logic meta_r;
    logic meta_nxt;
    logic sync_r;
    logic sync_nxt;
    logic prev_r;
    logic prev_nxt;

    // Shift the toggle through the chain
    always_comb begin
        meta_nxt = ev.src_tgl;
        sync_nxt = meta_r;
        prev_nxt = sync_r;
    end

    // Chain registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
            prev_r <= prev_nxt;
        end
    end

    // Edge of the settled toggle
    assign ev.dst_pulse = sync_r ^ prev_r;
endmodule

//--- logic/zaf_core.sv
// Purpose: Access control for the test, maker, counter and fuse cells and
//          the erase gate of the second application zone.
// Assumes: Link inputs are driven on link_clk; a request is held off by
//          link_req_ready until the previous answer has returned.
// Notes:   Requests cross by toggle handshake; the captured words stay
//          still until the answer comes back.
`timescale 1ns/1ps
module zaf_core (
    // System clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     rst,
    // Reader link, on the card clock
    input  wire logic                     link_clk,
    input  wire logic                     link_req_valid,
    output      logic                     link_req_ready,
    input  wire logic [1:0]               link_op,
    input  wire logic [2:0]               link_zone,
    input  wire logic [zaf_pkg::IDX_W-1:0] link_bit,
    output      logic                     link_done,
    output      logic                     link_granted,
    output      logic                     link_rdata,
    // Neighbouring access-control blocks
    input  wire logic                     access_password_ok,
    input  wire logic                     second_erase_key_ok,
    // Status
    output      logic                     code_verified_flag,
    output      logic                     security_mode2,
    output      logic                     counter_active,
    output      logic                     counter_spent,
    output      logic                     az2_erase_go
);
    // Link-domain state
    zaf_pkg::zaf_lk_state_t       lk_state_r;
    zaf_pkg::zaf_lk_state_t       lk_state_nxt;
    logic [1:0]                   rq_op_r;
    logic [1:0]                   rq_op_nxt;
    logic [2:0]                   rq_zone_r;
    logic [2:0]                   rq_zone_nxt;
    logic [zaf_pkg::IDX_W-1:0]    rq_bit_r;
    logic [zaf_pkg::IDX_W-1:0]    rq_bit_nxt;
    logic                         req_tgl_r;
    logic                         req_tgl_nxt;
    logic                         lk_done_r;
    logic                         lk_done_nxt;
    logic                         lk_grant_r;
    logic                         lk_grant_nxt;
    logic                         lk_rdata_r;
    logic                         lk_rdata_nxt;

    // System-domain state
    logic [zaf_pkg::WORD_BITS-1:0] tz_r;
    logic [zaf_pkg::WORD_BITS-1:0] tz_nxt;
    logic [zaf_pkg::WORD_BITS-1:0] mz_r;
    logic [zaf_pkg::WORD_BITS-1:0] mz_nxt;
    logic [zaf_pkg::WORD_BITS-1:0] iss_r;
    logic [zaf_pkg::WORD_BITS-1:0] iss_nxt;
    logic [zaf_pkg::CTR_BITS-1:0]  ctr_r;
    logic [zaf_pkg::CTR_BITS-1:0]  ctr_nxt;
    logic                          lim_r;
    logic                          lim_nxt;
    logic                          mf_r;
    logic                          mf_nxt;
    logic                          armed_r;
    logic                          armed_nxt;
    logic                          sv_r;
    logic                          sv_nxt;
    logic                          res_grant_r;
    logic                          res_grant_nxt;
    logic                          res_rdata_r;
    logic                          res_rdata_nxt;
    logic                          ack_tgl_r;
    logic                          ack_tgl_nxt;
    logic                          az2_go_r;
    logic                          az2_go_nxt;

    // Decoded request and derived security state
    logic                          req_pulse;
    logic                          ack_pulse;
    logic                          is_rd;
    logic                          is_wr;
    logic                          is_er;
    logic [zaf_pkg::WIDX_W-1:0]    w_idx;
    logic                          mode2;
    logic                          ctr_live;
    logic                          ctr_zero;
    logic                          az2_allow;

    // Event crossings in both directions
    zaf_evt_if req_evt ();
    zaf_evt_if ack_evt ();

    assign req_evt.src_tgl = req_tgl_r;
    assign ack_evt.src_tgl = ack_tgl_r;
    assign req_pulse       = req_evt.dst_pulse;
    assign ack_pulse       = ack_evt.dst_pulse;

    zaf_evt_sync u_req_sync (
        .clk (sys_clk),
        .rst (rst),
        .ev  (req_evt.sync)
    );

    zaf_evt_sync u_ack_sync (
        .clk (link_clk),
        .rst (rst),
        .ev  (ack_evt.sync)
    );

    // Link side: capture a request, wait for its answer
    always_comb begin
        lk_state_nxt = lk_state_r;
        rq_op_nxt    = rq_op_r;
        rq_zone_nxt  = rq_zone_r;
        rq_bit_nxt   = rq_bit_r;
        req_tgl_nxt  = req_tgl_r;
        lk_done_nxt  = 1'b0;
        lk_grant_nxt = lk_grant_r;
        lk_rdata_nxt = lk_rdata_r;
        case (lk_state_r)
            zaf_pkg::ZAF_LK_IDLE: begin
                if (link_req_valid) begin
                    rq_op_nxt    = link_op;
                    rq_zone_nxt  = link_zone;
                    rq_bit_nxt   = link_bit;
                    req_tgl_nxt  = ~req_tgl_r;
                    lk_state_nxt = zaf_pkg::ZAF_LK_WAIT;
                end
            end
            zaf_pkg::ZAF_LK_WAIT: begin
                if (ack_pulse) begin
                    lk_done_nxt  = 1'b1;
                    lk_grant_nxt = res_grant_r; // Held still since ack
                    lk_rdata_nxt = res_rdata_r;
                    lk_state_nxt = zaf_pkg::ZAF_LK_IDLE;
                end
            end
            default: begin
                lk_state_nxt = zaf_pkg::ZAF_LK_IDLE;
            end
        endcase
    end

    // Link-side registers
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            lk_state_r <= zaf_pkg::ZAF_LK_IDLE;
            rq_op_r    <= zaf_pkg::OP_READ;
            rq_zone_r  <= zaf_pkg::ZN_TEST;
            rq_bit_r   <= '0;
            req_tgl_r  <= 1'b0;
            lk_done_r  <= 1'b0;
            lk_grant_r <= 1'b0;
            lk_rdata_r <= 1'b0;
        end else begin
            lk_state_r <= lk_state_nxt;
            rq_op_r    <= rq_op_nxt;
            rq_zone_r  <= rq_zone_nxt;
            rq_bit_r   <= rq_bit_nxt;
            req_tgl_r  <= req_tgl_nxt;
            lk_done_r  <= lk_done_nxt;
            lk_grant_r <= lk_grant_nxt;
            lk_rdata_r <= lk_rdata_nxt;
        end
    end

    // Request decode and security state
    assign is_rd     = (rq_op_r == zaf_pkg::OP_READ);
    assign is_wr     = (rq_op_r == zaf_pkg::OP_WRITE);
    assign is_er     = (rq_op_r == zaf_pkg::OP_ERASE);
    assign w_idx     = rq_bit_r[zaf_pkg::WIDX_W-1:0];
    assign mode2     = (iss_r != zaf_pkg::ISSUER_RST); // [R13]
    assign ctr_live  = mode2 && lim_r;                 // [R01] [R06]
    assign ctr_zero  = (ctr_r == '0);
    // Counted erase needs a freshly spent bit; a spent counter blocks
    assign az2_allow = sv_r                                   // [R15]
                     && (!mode2 || second_erase_key_ok)       // [R15]
                     && (!ctr_live || armed_r)                // [R02] [R03]
                     && !(ctr_live && ctr_zero && !armed_r);  // [R04]

    // System side: judge and apply one request per crossing pulse
    always_comb begin
        tz_nxt        = tz_r;
        mz_nxt        = mz_r;
        iss_nxt       = iss_r;
        ctr_nxt       = ctr_r;
        lim_nxt       = lim_r;
        mf_nxt        = mf_r;
        armed_nxt     = armed_r;
        sv_nxt        = sv_r | access_password_ok; // [R14]
        res_grant_nxt = res_grant_r;
        res_rdata_nxt = res_rdata_r;
        ack_tgl_nxt   = ack_tgl_r;
        az2_go_nxt    = 1'b0;
        if (req_pulse) begin
            ack_tgl_nxt   = ~ack_tgl_r;
            res_grant_nxt = is_rd;
            res_rdata_nxt = 1'b1;
            case (rq_zone_r)
                zaf_pkg::ZN_TEST: begin
                    res_grant_nxt = 1'b1; // [R07]
                    res_rdata_nxt = tz_r[w_idx];
                    if (is_wr) begin
                        tz_nxt[w_idx] = 1'b0;
                    end else if (is_er) begin
                        tz_nxt = zaf_pkg::TEST_RST;
                    end
                end
                zaf_pkg::ZN_MAKER: begin
                    res_rdata_nxt = mz_r[w_idx]; // [R08]
                    if (!is_rd && sv_r && mf_r && !mode2) begin
                        res_grant_nxt = 1'b1; // [R09] [R10] [R11]
                        if (is_wr) begin
                            mz_nxt[w_idx] = 1'b0;
                        end else if (is_er) begin
                            mz_nxt = zaf_pkg::MAKER_RST;
                        end
                    end
                end
                zaf_pkg::ZN_COUNTER: begin
                    res_rdata_nxt = ctr_r[rq_bit_r];
                    // Erase falls through refused
                    if (is_wr && sv_r) begin // [R05]
                        res_grant_nxt    = 1'b1;
                        ctr_nxt[rq_bit_r] = 1'b0;
                        if (ctr_live && ctr_r[rq_bit_r]) begin
                            armed_nxt = 1'b1; // [R03]
                        end
                    end
                end
                zaf_pkg::ZN_LIMIT: begin
                    res_rdata_nxt = lim_r;
                    if (is_wr && sv_r && !mode2) begin // [R12]
                        res_grant_nxt = 1'b1;
                        lim_nxt       = 1'b0;
                    end
                end
                zaf_pkg::ZN_ISSUER: begin
                    res_rdata_nxt = iss_r[w_idx];
                    if (is_wr && sv_r) begin // [R16]
                        res_grant_nxt  = 1'b1;
                        iss_nxt[w_idx] = 1'b0;
                    end
                end
                zaf_pkg::ZN_MFUSE: begin
                    res_rdata_nxt = mf_r;
                    if (is_wr && sv_r) begin // [R16]
                        res_grant_nxt = 1'b1;
                        mf_nxt        = 1'b0;
                    end
                end
                zaf_pkg::ZN_AZ2: begin
                    // Reads and writes of the zone are judged elsewhere
                    res_grant_nxt = is_er && az2_allow;
                    if (is_er && az2_allow) begin
                        az2_go_nxt = 1'b1;
                        armed_nxt  = 1'b0; // Spent bit consumed
                    end
                end
                default: begin
                    res_grant_nxt = 1'b0;
                end
            endcase
        end
    end

    // System-side registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tz_r        <= zaf_pkg::TEST_RST;
            mz_r        <= zaf_pkg::MAKER_RST;
            iss_r       <= zaf_pkg::ISSUER_RST;
            ctr_r       <= zaf_pkg::CTR_RST;
            lim_r       <= zaf_pkg::LIMIT_RST;
            mf_r        <= zaf_pkg::MFUSE_RST;
            armed_r     <= 1'b0;
            sv_r        <= 1'b0;
            res_grant_r <= 1'b0;
            res_rdata_r <= 1'b0;
            ack_tgl_r   <= 1'b0;
            az2_go_r    <= 1'b0;
        end else begin
            tz_r        <= tz_nxt;
            mz_r        <= mz_nxt;
            iss_r       <= iss_nxt;
            ctr_r       <= ctr_nxt;
            lim_r       <= lim_nxt;
            mf_r        <= mf_nxt;
            armed_r     <= armed_nxt;
            sv_r        <= sv_nxt;
            res_grant_r <= res_grant_nxt;
            res_rdata_r <= res_rdata_nxt;
            ack_tgl_r   <= ack_tgl_nxt;
            az2_go_r    <= az2_go_nxt;
        end
    end

    // Outputs
    assign link_req_ready     = (lk_state_r == zaf_pkg::ZAF_LK_IDLE);
    assign link_done          = lk_done_r;
    assign link_granted       = lk_grant_r;
    assign link_rdata         = lk_rdata_r;
    assign code_verified_flag = sv_r;
    assign security_mode2     = mode2;
    assign counter_active     = ctr_live;
    assign counter_spent      = ctr_live && ctr_zero && !armed_r;
    assign az2_erase_go       = az2_go_r;

    // Checks on the system clock
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    counter_gate_a: assert property ( // [R01]
        ctr_live |-> (iss_r != zaf_pkg::ISSUER_RST) && lim_r)
        else $error("counter live outside mode 2 with limit fuse set");

    counted_erase_a: assert property ( // [R02]
        $rose(az2_go_r) && $past(ctr_live) |-> $past(armed_r)
                                               && !armed_r)
        else $error("counted erase without a spent counter bit");

    spend_arms_a: assert property ( // [R03]
        req_pulse && is_wr && sv_r && ctr_live
        && rq_zone_r == zaf_pkg::ZN_COUNTER && ctr_r[rq_bit_r]
        |=> armed_r && !ctr_r[$past(rq_bit_r)])
        else $error("counter bit write did not arm the erase");

    spent_refuse_a: assert property ( // [R04]
        req_pulse && rq_zone_r == zaf_pkg::ZN_AZ2 && ctr_live
        && ctr_zero && !armed_r |=> !res_grant_r && !az2_go_r)
        else $error("erase granted on a spent counter");

    ctr_no_erase_a: assert property ( // [R05]
        req_pulse && is_er && rq_zone_r == zaf_pkg::ZN_COUNTER
        |=> !res_grant_r && $stable(ctr_r))
        else $error("counter erase was not refused");

    unlimited_a: assert property ( // [R06]
        req_pulse && is_er && rq_zone_r == zaf_pkg::ZN_AZ2 && mode2
        && !lim_r && sv_r && second_erase_key_ok |=> az2_go_r)
        else $error("unlimited erase was refused");

    test_open_a: assert property ( // [R07]
        req_pulse && rq_zone_r == zaf_pkg::ZN_TEST |=> res_grant_r
                                                      ##1 !az2_go_r)
        else $error("test zone access refused");

    maker_read_a: assert property ( // [R08]
        req_pulse && is_rd && rq_zone_r == zaf_pkg::ZN_MAKER
        |=> res_grant_r && res_rdata_r == $past(mz_r[w_idx]))
        else $error("maker zone read refused or wrong");

    maker_lock_a: assert property ( // [R09]
        req_pulse && !is_rd && rq_zone_r == zaf_pkg::ZN_MAKER
        && (!sv_r || !mf_r || mode2) |=> !res_grant_r
                                         && $stable(mz_r))
        else $error("locked maker zone changed");

    limit_frozen_a: assert property ( // [R12]
        mode2 |=> $stable(lim_r))
        else $error("limit fuse changed in mode 2");

    mode_sticky_a: assert property ( // [R13]
        mode2 |=> mode2 ##1 mode2)
        else $error("security mode fell back to 1");

    verify_flag_a: assert property ( // [R14]
        access_password_ok |=> sv_r [*3])
        else $error("verified flag not held");

    key_gate_a: assert property ( // [R15]
        $rose(az2_go_r) |-> $past(sv_r)
                            && (!$past(mode2) || $past(second_erase_key_ok)))
        else $error("second zone erase without code and key");

    fuse_oneway_a: assert property ( // [R16]
        !$rose(lim_r) && !$rose(mf_r)
        && ((~$past(iss_r) & iss_r) == '0))
        else $error("fuse bit returned to one");

    // Main scenarios
    counted_erase_c: cover property (
        ctr_live && armed_r ##1 az2_go_r);
    counter_spent_c: cover property (
        ctr_live && ctr_zero && !armed_r);
    maker_write_c: cover property (
        req_pulse && is_wr && rq_zone_r == zaf_pkg::ZN_MAKER ##1 res_grant_r);
    erase_refused_c: cover property (
        req_pulse && is_er && rq_zone_r == zaf_pkg::ZN_AZ2 ##1 !res_grant_r);
endmodule

//--- bench/zaf_reader.sv
// Purpose: Card reader model for the link side of the zone logic.
// Assumes: One request at a time, offered on the falling link edge.
// Notes:   Link clock runs only in frames; released lines invert.
`timescale 1ns/1ps
module zaf_reader (
    // Link clock and request
    output logic                      link_clk,
    output logic                      link_req_valid,
    output logic [1:0]                link_op,
    output logic [2:0]                link_zone,
    output logic [zaf_pkg::IDX_W-1:0] link_bit,
    // Answer
    input  wire logic                 link_req_ready,
    input  wire logic                 link_done,
    input  wire logic                 link_granted,
    input  wire logic                 link_rdata
);
    // Idle at time zero, clock stopped
    initial begin
        link_clk = 1'b0;
        link_req_valid = 1'b0;
        {link_op, link_zone, link_bit} = 12'h000;
    end
    // Free cycles while the block is in reset
    task automatic tick(input int n);
        repeat (n) begin
            link_clk = 1'b1;
            #16 link_clk = 1'b0;
            #16;
        end
    endtask
    // Hold the request to the taking edge, then wait for done
    task automatic xfer(input logic [1:0] o, input logic [2:0] z,
                        input logic [6:0] b, output logic g,
                        output logic r, output bit ok);
        bit tk;
        ok = 1'b0;
        tk = 1'b0;
        {link_op, link_zone, link_bit} = {o, z, b};
        link_req_valid = 1'b1;
        for (int n = 0; n < 14 && !ok; n++) begin
            #16 tk = tk | (link_req_valid && link_req_ready === 1'b1);
            link_clk = 1'b1;
            #16 link_clk = 1'b0;
            // Released lines no longer show the last value
            if (tk && link_req_valid) begin
                link_req_valid = 1'b0;
                {link_op, link_zone, link_bit} = ~{o, z, b};
            end
            if (link_done === 1'b1) begin
                {g, r, ok} = {link_granted, link_rdata, 1'b1};
            end
        end
    endtask
endmodule

//--- bench/tb.sv
// Purpose: Self-checking bench for the zone access and fuse logic.
// Assumes: Side inputs change on falling sys_clk edges.
// Notes:   A second reset sets up the unlimited erase case.
`timescale 1ns/1ps
module tb;
    // Clock, reset and side inputs
    logic       sys_clk = 1'b0;
    logic       rst = 1'b1;
    logic       pw = 1'b0;
    logic       key = 1'b0;
    // Link and status
    logic       lclk, vld, rdy, dn, gr, rd, rv;
    logic       flag, md2, act, spt, go;
    logic [1:0] op;
    logic [2:0] zn;
    logic [6:0] bn;
    int         n_fail = 0;
    int         check_count = 0;
    int         go_cnt = 0;
    logic       gr_q;

    always #4 sys_clk = ~sys_clk;
    // Count erase pulses of the second zone
    always @(posedge sys_clk) begin
        if (go === 1'b1) go_cnt <= go_cnt + 1;
    end

    zaf_core u_zaf_core (.sys_clk(sys_clk), .rst(rst), .link_clk(lclk),
        .link_req_valid(vld), .link_req_ready(rdy), .link_op(op),
        .link_zone(zn), .link_bit(bn), .link_done(dn), .link_granted(gr),
        .link_rdata(rd), .access_password_ok(pw), .second_erase_key_ok(key),
        .code_verified_flag(flag), .security_mode2(md2),
        .counter_active(act), .counter_spent(spt), .az2_erase_go(go));
    zaf_reader u_zaf_reader (.link_clk(lclk), .link_req_valid(vld),
        .link_op(op), .link_zone(zn), .link_bit(bn), .link_req_ready(rdy),
        .link_done(dn), .link_granted(gr), .link_rdata(rd));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input string nm, input logic s, input logic e);
        check_count++;
        if (s !== e) begin
            n_fail++;
            $display("BAD %s expected %b seen %b", nm, e, s);
        end
    endtask
    // One link request, judged on its grant
    task automatic acc(input logic [1:0] o, input logic [2:0] z,
                       input logic [6:0] b, input logic e);
        bit ok;
        u_zaf_reader.xfer(o, z, b, gr_q, rv, ok);
        if (!ok) begin
            check("link done", 1'b0, 1'b1);
            give_verdict();
        end
        check("grant", gr_q, e);
    endtask
    task automatic wr(input logic [2:0] z, input logic [6:0] b, logic e);
        acc(zaf_pkg::OP_WRITE, z, b, e);
    endtask
    task automatic er(input logic [2:0] z, input logic e);
        acc(zaf_pkg::OP_ERASE, z, 7'h00, e);
    endtask
    task automatic rdc(input logic [2:0] z, input logic [6:0] b, logic e);
        acc(zaf_pkg::OP_READ, z, b, 1'b1);
        check("read bit", rv, e);
    endtask
    task automatic do_reset();
        @(negedge sys_clk) rst = 1'b1;
        key = 1'b0;
        fork
            begin repeat (5) @(negedge sys_clk); rst = 1'b0; end
            u_zaf_reader.tick(2);
        join
        repeat (2) @(negedge sys_clk);
        go_cnt = 0;
    endtask
    task automatic pwd();
        @(negedge sys_clk) pw = 1'b1;
        @(negedge sys_clk) pw = 1'b0;
        check("verified", flag, 1'b1);
    endtask
    task automatic t_open();
        check("mode2", md2, 1'b0);
        check("active", act, 1'b0);
        wr(zaf_pkg::ZN_TEST, 7'h03, 1'b1);
        rdc(zaf_pkg::ZN_TEST, 7'h03, 1'b0);
        er(zaf_pkg::ZN_TEST, 1'b1);
        rdc(zaf_pkg::ZN_TEST, 7'h03, 1'b1);
        wr(zaf_pkg::ZN_MAKER, 7'h05, 1'b0);
        er(zaf_pkg::ZN_AZ2, 1'b0);
        pwd();
        wr(zaf_pkg::ZN_MAKER, 7'h05, 1'b1);
        rdc(zaf_pkg::ZN_MAKER, 7'h05, 1'b0);
        er(zaf_pkg::ZN_MAKER, 1'b1);
        er(zaf_pkg::ZN_AZ2, 1'b1);
        er(zaf_pkg::ZN_ISSUER, 1'b0);
    endtask
    task automatic t_count();
        wr(zaf_pkg::ZN_ISSUER, 7'h02, 1'b1);
        check("mode2", md2, 1'b1);
        check("active", act, 1'b1);
        wr(zaf_pkg::ZN_LIMIT, 7'h00, 1'b0);
        rdc(zaf_pkg::ZN_LIMIT, 7'h00, 1'b1);
        wr(zaf_pkg::ZN_MAKER, 7'h01, 1'b0);
        er(zaf_pkg::ZN_AZ2, 1'b0);
        er(zaf_pkg::ZN_COUNTER, 1'b0);
        for (int i = 0; i < 128; i++) begin
            wr(zaf_pkg::ZN_COUNTER, 7'(i), 1'b1);
            if (i == 0) begin
                er(zaf_pkg::ZN_AZ2, 1'b0);
                @(negedge sys_clk) key = 1'b1;
            end
            er(zaf_pkg::ZN_AZ2, 1'b1);
        end
        check("go count", go_cnt == 129, 1'b1);
        check("spent", spt, 1'b1);
        wr(zaf_pkg::ZN_COUNTER, 7'h05, 1'b1);
        er(zaf_pkg::ZN_AZ2, 1'b0);
        check("go count", go_cnt == 129, 1'b1);
    endtask
    task automatic t_free();
        do_reset();
        pwd();
        wr(zaf_pkg::ZN_LIMIT, 7'h00, 1'b1);
        wr(zaf_pkg::ZN_MFUSE, 7'h00, 1'b1);
        wr(zaf_pkg::ZN_MAKER, 7'h02, 1'b0);
        er(zaf_pkg::ZN_MFUSE, 1'b0);
        wr(zaf_pkg::ZN_ISSUER, 7'h00, 1'b1);
        check("active", act, 1'b0);
        @(negedge sys_clk) key = 1'b1;
        repeat (3) er(zaf_pkg::ZN_AZ2, 1'b1);
        check("go count", go_cnt == 3, 1'b1);
    endtask
    initial begin
        do_reset();
        t_open();
        t_count();
        t_free();
        give_verdict();
    end
endmodule
